// *** design/dlp_pkg.sv ***
// package for the converter latch and power-down control block
// assumes a single 10 MHz clock domain and a plain register port
package dlp_pkg;
    localparam int CODE_W = 12;
    localparam int NCH = 2;
    localparam logic [3:0] ADDR_CODE0 = 4'h0;
    localparam logic [3:0] ADDR_CODE1 = 4'h1;
    localparam logic [3:0] ADDR_PWRDN = 4'h2;
    localparam logic [3:0] ADDR_GAIN_STATUS = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [1:0] PD_PULL_1K = 2'h1;
    localparam logic [1:0] PD_PULL_100K = 2'h2;
    localparam logic [1:0] PD_OPEN = 2'h3;
    localparam logic [CODE_W-1:0] CODE_DEFAULT = 12'h7ff;
    localparam logic [1:0] PD_DEFAULT = 2'h0;
    localparam logic [4:0] CFG_DEFAULT = 5'h00;
    localparam int CLK_HZ = 10000000;
    localparam int ENTRY_DELAY_NS = 10000;
    localparam int EXIT_DELAY_NS = 10000;
    localparam int ENTRY_CYC = (ENTRY_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int EXIT_CYC = (EXIT_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int CNT_W = 8;
    localparam int IRQ_W = 4;
    localparam int IRQ_LATCH = 0;
    localparam int IRQ_PD_IN = 1;
    localparam int IRQ_PD_OUT = 2;
    localparam int IRQ_POR = 3;
    typedef struct packed {
        logic amp_on;
        logic ladder_on;
        logic ref_conn;
        logic pull_1k;
        logic pull_100k;
    } dlp_out_ctl_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dlp_bus_req_t;
endpackage : dlp_pkg

// *** design/dlp_ctrl.sv ***
// latch, power-down and volatile memory control of a dual converter
// assumes registers are reached over a plain strobe port on clk
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module dlp_ctrl #(
    parameter int CODE_W = dlp_pkg::CODE_W,
    parameter int NCH = dlp_pkg::NCH
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, power-on event
    input wire logic transfer_hold_pin, // async hold input, high blocks transfer
    input wire logic [3:0] addr, // register address
    input wire logic [15:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [15:0] rdata, // read data, one cycle after rd
    output logic [NCH*CODE_W-1:0] out_code, // output stage codes
    output dlp_pkg::dlp_out_ctl_t [NCH-1:0] out_ctl, // per channel analog controls
    output logic irq // level interrupt
);
    ////////////////////////////////////////////////////////////////////////
    // local field positions and widths
    localparam int IRQ_W_L = dlp_pkg::IRQ_W;
    localparam int CFG_W = 5;
    localparam int PD_W = 2;
    localparam int HOLD_BIT = 6;
    localparam int POR_BIT = 7;

    ////////////////////////////////////////////////////////////////////////
    // hold synchroniser and edge detector
    logic hold_s1_r;
    logic hold_s2_r;
    logic hold_d_r;
    logic [CODE_W-1:0] code_r [NCH];
    logic [CODE_W-1:0] stage_r [NCH];
    logic [PD_W-1:0] pwrdn_select_r [NCH];
    logic [CFG_W-1:0] cfg_r;
    logic por_flag_r;
    logic [IRQ_W_L-1:0] irq_stat_r;
    logic [IRQ_W_L-1:0] irq_mask_r;
    logic [IRQ_W_L-1:0] irq_ev;
    logic [NCH-1:0] ent_ev;
    logic [NCH-1:0] ext_ev;
    logic [15:0] rd_mux;
    logic wr_cfg;
    logic wr_pwrdn;
    logic wr_irq_stat;
    logic wr_irq_mask;
    logic rd_status;

    ////////////////////////////////////////////////////////////////////////
    // register port decode, live in every power-down mode
    assign wr_cfg = wr && addr == dlp_pkg::ADDR_GAIN_STATUS;
    assign wr_pwrdn = wr && addr == dlp_pkg::ADDR_PWRDN;
    assign wr_irq_stat = wr && addr == dlp_pkg::ADDR_IRQ_STATUS;
    assign wr_irq_mask = wr && addr == dlp_pkg::ADDR_IRQ_MASK;
    assign rd_status = rd && addr == dlp_pkg::ADDR_GAIN_STATUS;

    ////////////////////////////////////////////////////////////////////////
    // synchroniser: first stage read only by second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // idle low level, so no false release edge follows reset
            hold_s1_r <= 1'b0;
            hold_s2_r <= 1'b0;
            hold_d_r <= 1'b0;
        end
        else
        begin
            hold_s1_r <= transfer_hold_pin;
            hold_s2_r <= hold_s1_r;
            hold_d_r <= hold_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cfg_r <= dlp_pkg::CFG_DEFAULT;
        end
        else if (wr_cfg)
        begin
            cfg_r <= wdata[CFG_W-1:0];
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++)
        begin : g_ch
            localparam logic [3:0] CA = dlp_pkg::ADDR_CODE0 + 4'(ch);
            localparam int CNT_W_L = dlp_pkg::CNT_W;
            logic [CNT_W_L-1:0] cnt_r;
            logic pd_eff_r;
            logic sel_nz;
            assign sel_nz = pwrdn_select_r[ch] != dlp_pkg::PD_NORMAL;

            // code writes are taken whether or not transfers are held
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    code_r[ch] <= dlp_pkg::CODE_DEFAULT[CODE_W-1:0];
                end
                else if (wr && addr == CA)
                begin
                    code_r[ch] <= wdata[CODE_W-1:0];
                end
            end

            // level-driven transfer, shared hold for all channels
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    stage_r[ch] <= dlp_pkg::CODE_DEFAULT[CODE_W-1:0];
                end
                else if (!hold_s2_r)
                begin
                    stage_r[ch] <= code_r[ch];
                end
            end

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    pwrdn_select_r[ch] <= dlp_pkg::PD_DEFAULT;
                end
                else if (wr_pwrdn)
                begin
                    pwrdn_select_r[ch] <= wdata[PD_W*ch+PD_W-1 -: PD_W];
                end
            end

            // delay counter for entry and exit
            // a select that reverts before the count ends cancels the change
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    pd_eff_r <= 1'b0;
                    cnt_r <= '0;
                end
                else if (sel_nz == pd_eff_r)
                begin
                    cnt_r <= '0;
                end
                else if (sel_nz && cnt_r >= CNT_W_L'(dlp_pkg::ENTRY_CYC - 1))
                begin
                    pd_eff_r <= 1'b1;
                    cnt_r <= '0;
                end
                else if (!sel_nz && cnt_r >= CNT_W_L'(dlp_pkg::EXIT_CYC - 1))
                begin
                    pd_eff_r <= 1'b0;
                    cnt_r <= '0;
                end
                else
                begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    out_ctl[ch].amp_on <= 1'b1;
                    out_ctl[ch].ladder_on <= 1'b1;
                    out_ctl[ch].ref_conn <= 1'b1;
                    out_ctl[ch].pull_1k <= 1'b0;
                    out_ctl[ch].pull_100k <= 1'b0;
                end
                else
                begin
                    out_ctl[ch].amp_on <= !pd_eff_r;
                    out_ctl[ch].ladder_on <= !pd_eff_r;
                    out_ctl[ch].ref_conn <= !pd_eff_r;
                    out_ctl[ch].pull_1k <= pd_eff_r
                        && pwrdn_select_r[ch] == dlp_pkg::PD_PULL_1K;
                    out_ctl[ch].pull_100k <= pd_eff_r
                        && pwrdn_select_r[ch] == dlp_pkg::PD_PULL_100K;
                end
            end

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    out_code[ch*CODE_W +: CODE_W] <= dlp_pkg::CODE_DEFAULT[CODE_W-1:0];
                end
                else
                begin
                    out_code[ch*CODE_W +: CODE_W] <= stage_r[ch];
                end
            end

            // one-cycle pulses when a pending entry or exit completes
            assign ent_ev[ch] = sel_nz && !pd_eff_r && cnt_r >= CNT_W_L'(dlp_pkg::ENTRY_CYC - 1);
            assign ext_ev[ch] = !sel_nz && pd_eff_r && cnt_r >= CNT_W_L'(dlp_pkg::EXIT_CYC - 1);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            por_flag_r <= 1'b1;
        end
        // only reset sets the flag, so no set can meet the read clear
        else if (rd_status)
        begin
            por_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky, write one to clear, set wins
    always_comb
    begin
        irq_ev = '0;
        // falling edge of the synchronised hold level
        irq_ev[dlp_pkg::IRQ_LATCH] = hold_d_r && !hold_s2_r;
        irq_ev[dlp_pkg::IRQ_PD_IN] = |ent_ev;
        irq_ev[dlp_pkg::IRQ_PD_OUT] = |ext_ev;
        irq_ev[dlp_pkg::IRQ_POR] = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_stat_r <= IRQ_W_L'(1) << dlp_pkg::IRQ_POR;
            irq_mask_r <= '0;
        end
        else
        begin
            if (wr_irq_stat)
            begin
                irq_stat_r <= (irq_stat_r & ~wdata[IRQ_W_L-1:0]) | irq_ev;
            end
            else
            begin
                irq_stat_r <= irq_stat_r | irq_ev;
            end
            if (wr_irq_mask)
            begin
                irq_mask_r <= wdata[IRQ_W_L-1:0];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            // level output, one cycle behind the status bits
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port always live, also in power-down; unmapped addresses read zero
    always_comb
    begin
        rd_mux = '0;
        if (addr == dlp_pkg::ADDR_CODE0)
        begin
            rd_mux[CODE_W-1:0] = code_r[0];
        end
        else if (addr == dlp_pkg::ADDR_CODE1 && NCH > 1)
        begin
            rd_mux[CODE_W-1:0] = code_r[NCH-1];
        end
        else if (addr == dlp_pkg::ADDR_PWRDN)
        begin
            rd_mux[PD_W-1:0] = pwrdn_select_r[0];
            rd_mux[2*PD_W-1:PD_W] = pwrdn_select_r[NCH-1];
        end
        else if (addr == dlp_pkg::ADDR_GAIN_STATUS)
        begin
            rd_mux[CFG_W-1:0] = cfg_r;
            rd_mux[HOLD_BIT] = hold_s2_r;
            rd_mux[POR_BIT] = por_flag_r;
        end
        else if (addr == dlp_pkg::ADDR_IRQ_STATUS)
        begin
            rd_mux[IRQ_W_L-1:0] = irq_stat_r;
        end
        else if (addr == dlp_pkg::ADDR_IRQ_MASK)
        begin
            rd_mux[IRQ_W_L-1:0] = irq_mask_r;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata <= '0;
        end
        else if (rd)
        begin
            rdata <= rd_mux;
        end
        else
        begin
            rdata <= '0;
        end
    end
endmodule : dlp_ctrl

// *** bench/dlp_ctrl_asserts.sv ***
// concurrent checks on the latch and power-down control ports
// assumes binding into dlp_ctrl, one clock, sync reset
`timescale 1ns/100ps
module dlp_ctrl_asserts #(
    parameter int CODE_W = 12,
    parameter int NCH = 2
) (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic transfer_hold_pin, // hold
    input wire logic [3:0] addr, // address
    input wire logic [15:0] wdata, // data in
    input wire logic wr, // write
    input wire logic rd, // read
    input wire logic [15:0] rdata, // data out
    input wire logic [NCH*CODE_W-1:0] out_code, // codes
    input wire dlp_pkg::dlp_out_ctl_t [NCH-1:0] out_ctl, // controls
    input wire logic irq // interrupt
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    sequence pd_on_wr;
        wr && addr == dlp_pkg::ADDR_PWRDN && wdata[1:0] != 2'h0 && out_ctl[0].amp_on;
    endsequence
    sequence pd_off_wr;
        wr && addr == dlp_pkg::ADDR_PWRDN && wdata[1:0] == 2'h0 && !out_ctl[0].amp_on;
    endsequence
    sequence status_rd;
        rd && addr == dlp_pkg::ADDR_GAIN_STATUS;
    endsequence
    hold_block_a: assert property (transfer_hold_pin [*4] |=> $stable(out_code))
        else $error("output code moved while held");
    code_follow_a: assert property (!transfer_hold_pin [*3] ##0 (wr && addr ==
        dlp_pkg::ADDR_CODE0) |-> ##3 out_code[11:0] == $past(wdata[11:0], 3))
        else $error("output code did not follow write");
    por_clear_a: assert property (status_rd ##1 status_rd |=> rdata[7] == 1'b0)
        else $error("power-on flag not cleared by read");
    rdata_idle_a: assert property (!rd |=> rdata == 16'h0)
        else $error("read data not zero when idle");
    irq_mask_a: assert property ((wr && addr == dlp_pkg::ADDR_IRQ_MASK && wdata[3:0] == 4'h0)
        ##1 !wr |=> !irq)
        else $error("masked interrupt raised");
    pd_entry_a: assert property (pd_on_wr |-> ##[95:110] $fell(out_ctl[0].amp_on))
        else $error("entry delay wrong");
    pd_exit_a: assert property (pd_off_wr |-> ##[95:110] $rose(out_ctl[0].amp_on))
        else $error("exit delay wrong");
    pd_ctl_a: assert property (out_ctl[0].ladder_on == out_ctl[0].amp_on && out_ctl[0].ref_conn
        == out_ctl[0].amp_on && !(out_ctl[0].amp_on && (out_ctl[0].pull_1k ||
        out_ctl[0].pull_100k)) && !(out_ctl[0].pull_1k && out_ctl[0].pull_100k))
        else $error("analog controls inconsistent");
endmodule : dlp_ctrl_asserts
bind dlp_ctrl dlp_ctrl_asserts #(.CODE_W(CODE_W), .NCH(NCH)) u_dlp_ctrl_asserts (.clk(clk),
    .rst(rst), .transfer_hold_pin(transfer_hold_pin), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .out_code(out_code), .out_ctl(out_ctl), .irq(irq));

// *** bench/dlp_host.sv ***
// host model: register port master and transfer-hold driver
// assumes the device samples strobes on the rising clk edge
`timescale 1ns/100ps
module dlp_host (
    input wire logic clk, // clock
    input wire logic [15:0] rdata, // data out
    output logic [3:0] addr, // address
    output logic [15:0] wdata, // data in
    output logic wr, // write
    output logic rd, // read
    output logic transfer_hold_pin // hold
);
    initial
    begin
        addr = 4'h0;
        wdata = 16'h0;
        wr = 1'b0;
        rd = 1'b0;
        transfer_hold_pin = 1'b0;
    end
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask : wr_reg
    // two reads back to back, answers taken at the edge where each stands
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d1, output logic [15:0] d2);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        d1 = rdata;
        @(posedge clk);
        d2 = rdata;
    endtask : rd_reg
    task automatic set_hold(input logic v);
        @(posedge clk);
        transfer_hold_pin <= v;
    endtask : set_hold
endmodule : dlp_host

// *** bench/dlp_ctrl_bench.sv ***
// self-checking bench for the latch and power-down control block
// assumes the host model drives every register port input
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module dlp_ctrl_bench;
    logic clk;
    logic rst;
    logic hold;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, d1, d2;
    logic wr, rd, irq;
    logic [23:0] out_code, prev;
    dlp_pkg::dlp_out_ctl_t [1:0] out_ctl;
    logic [31:0] seed;
    logic [1:0] pm;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    dlp_ctrl u_dlp_ctrl (.clk(clk), .rst(rst), .transfer_hold_pin(hold), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .out_code(out_code),
        .out_ctl(out_ctl), .irq(irq));
    dlp_host u_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .transfer_hold_pin(hold));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction : xs
    function automatic dlp_pkg::dlp_out_ctl_t exp_ctl(input logic [1:0] m);
        exp_ctl = (m == 2'h0) ? 5'b11100 : {3'b000, m == 2'h1, m == 2'h2};
    endfunction : exp_ctl
    task automatic test_done();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            err_count++;
            test_done();
        end
    end
    initial
    begin
        seed = 32'hfdf0bf32;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(out_code, {2{dlp_pkg::CODE_DEFAULT}})
        `CHK(out_ctl, {2{exp_ctl(dlp_pkg::PD_DEFAULT)}})
        u_host.rd_reg(dlp_pkg::ADDR_GAIN_STATUS, d1, d2);
        `CHK(d1[7], 1'b1)
        `CHK(d2[7], 1'b0)
        u_host.rd_reg(dlp_pkg::ADDR_IRQ_STATUS, d1, d2);
        `CHK(d1[3:0], 4'h8)
        `CHK(irq, 1'b0)
        u_host.wr_reg(dlp_pkg::ADDR_IRQ_MASK, 16'h8);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b1)
        u_host.wr_reg(dlp_pkg::ADDR_IRQ_STATUS, 16'h8);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        u_host.wr_reg(dlp_pkg::ADDR_IRQ_MASK, 16'h0);
        u_host.wr_reg(4'hf, 16'hffff);
        u_host.rd_reg(4'hf, d1, d2);
        `CHK(d1, 16'h0)
        seed = xs(seed);
        u_host.wr_reg(dlp_pkg::ADDR_GAIN_STATUS, {8'h0, 3'b110, seed[4:0]});
        u_host.rd_reg(dlp_pkg::ADDR_GAIN_STATUS, d1, d2);
        `CHK(d1[7:0], {3'b000, seed[4:0]})
        repeat (8)
        begin
            seed = xs(seed);
            u_host.wr_reg(seed[12] ? dlp_pkg::ADDR_CODE1 : dlp_pkg::ADDR_CODE0,
                {4'h0, seed[11:0]});
            repeat (5) @(posedge clk);
            `CHK(out_code[(seed[12] ? 12 : 0) +: 12], seed[11:0])
        end
        prev = out_code;
        u_host.set_hold(1'b1);
        repeat (3) @(posedge clk);
        u_host.wr_reg(dlp_pkg::ADDR_CODE0, {4'h0, ~prev[11:0]});
        u_host.wr_reg(dlp_pkg::ADDR_CODE1, {4'h0, ~prev[23:12]});
        repeat (6) @(posedge clk);
        `CHK(out_code, prev)
        u_host.rd_reg(dlp_pkg::ADDR_CODE1, d1, d2);
        `CHK(d1[11:0], ~prev[23:12])
        u_host.set_hold(1'b0);
        for (int i = 0; i < 10 && out_code === prev; i++)
            @(posedge clk);
        `CHK(out_code, ~prev)
        u_host.rd_reg(dlp_pkg::ADDR_IRQ_STATUS, d1, d2);
        `CHK(d1[3:0], 4'h1)
        u_host.wr_reg(dlp_pkg::ADDR_IRQ_STATUS, 16'hf);
        for (int m = 1; m < 4; m++)
        begin
            pm = m[1:0];
            u_host.wr_reg(dlp_pkg::ADDR_PWRDN, {12'h0, ~pm, pm});
            repeat (8) @(posedge clk);
            `CHK(out_ctl[0], exp_ctl(dlp_pkg::PD_NORMAL))
            repeat (110) @(posedge clk);
            `CHK(out_ctl, {exp_ctl(~pm), exp_ctl(pm)})
            seed = xs(seed);
            u_host.wr_reg(dlp_pkg::ADDR_CODE0, {4'h0, seed[11:0]});
            u_host.rd_reg(dlp_pkg::ADDR_PWRDN, d1, d2);
            `CHK(d1[3:0], {~pm, pm})
            u_host.wr_reg(dlp_pkg::ADDR_PWRDN, 16'h0);
            repeat (8) @(posedge clk);
            `CHK(out_ctl[0].amp_on, 1'b0)
            repeat (110) @(posedge clk);
            `CHK(out_ctl, {2{exp_ctl(dlp_pkg::PD_NORMAL)}})
            `CHK(out_code[11:0], seed[11:0])
            u_host.rd_reg(dlp_pkg::ADDR_IRQ_STATUS, d1, d2);
            `CHK(d1[3:0], 4'h6)
            u_host.wr_reg(dlp_pkg::ADDR_IRQ_STATUS, 16'h6);
        end
        test_done();
    end
endmodule : dlp_ctrl_bench
